// file: host_bus_if.sv
// Purpose: carries synchronised host bus events from the pin stage to the register core
// Assumes: every signal is in the ref_clk_in domain
// Notes:   pulses last one cycle
`timescale 1ns/100ps
interface host_bus_if;
  logic                      mode;
  logic                      reset_active;
  logic                      wr_pulse;
  logic                      rd_pulse;
  logic                      rd_level;
  logic [4:0]                addr;
  quad_uart_pkg::byte_t      data;
  quad_uart_pkg::chan_vec_t  ring_n;
  quad_uart_pkg::chan_vec_t  ring_rise;
  quad_uart_pkg::chan_vec_t  rx;

  modport sync_side (output mode, reset_active, wr_pulse, rd_pulse, rd_level,
                     output addr, data, ring_n, ring_rise, rx);
  modport core_side (input mode, reset_active, wr_pulse, rd_pulse, rd_level,
                     input addr, data, ring_n, ring_rise, rx);
endinterface

// file: host_pin_sync.sv
// Purpose: two-stage synchronisers and edge detection for host and modem pins
// Assumes: host holds address and data stable around its strobe
// Notes:   mode 1 = separate strobes, mode 0 = combined read/write select
`timescale 1ns/100ps
`include "quad_uart_defines.svh"
module host_pin_sync (
  input  wire logic               ref_clk_in,
  input  wire logic               rst_in,
  input  wire logic [`SYNC_W-1:0] pins_in,
  host_bus_if.sync_side           bus
);
  logic [`SYNC_W-1:0] s1_ff;
  logic [`SYNC_W-1:0] s2_ff;
  logic [`SYNC_W-1:0] prev_ff;
  logic [`SYNC_W-1:0] nxt_s1;
  logic [`SYNC_W-1:0] nxt_s2;
  logic [`SYNC_W-1:0] nxt_prev;
  logic               cs_n;
  logic               cs_fall;
  logic               wr_fall;
  logic               rd_fall;

  // ****************************************
  // synchroniser stages
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g = g + 1) begin : g_sync
      always_comb begin
        nxt_s1[g]   = pins_in[g];
        nxt_s2[g]   = s1_ff[g];
        nxt_prev[g] = s2_ff[g];
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_ff   <= {`SYNC_W{1'b1}};
      s2_ff   <= {`SYNC_W{1'b1}};
      prev_ff <= {`SYNC_W{1'b1}};
    end else begin
      s1_ff   <= nxt_s1;
      s2_ff   <= nxt_s2;
      prev_ff <= nxt_prev;
    end
  end

  // ****************************************
  // edge detection and bus style decode
  // ****************************************
  always_comb begin
    cs_n    = s2_ff[`SYNC_CS];
    cs_fall = prev_ff[`SYNC_CS] & ~s2_ff[`SYNC_CS];
    wr_fall = prev_ff[`SYNC_WR] & ~s2_ff[`SYNC_WR];
    rd_fall = prev_ff[`SYNC_RD] & ~s2_ff[`SYNC_RD];
    bus.mode = s2_ff[`SYNC_MODE];
    bus.reset_active = bus.mode ? s2_ff[`SYNC_RST] : ~s2_ff[`SYNC_RST];
    if (bus.mode) begin
      bus.wr_pulse = ~cs_n & wr_fall;
      bus.rd_pulse = ~cs_n & rd_fall;
      bus.rd_level = ~cs_n & ~s2_ff[`SYNC_RD];
    end else begin
      bus.wr_pulse = cs_fall & ~s2_ff[`SYNC_WR];
      bus.rd_pulse = cs_fall & s2_ff[`SYNC_WR];
      bus.rd_level = ~cs_n & s2_ff[`SYNC_WR];
    end
    bus.addr      = s2_ff[`SYNC_ADDR +: 5];
    bus.data      = s2_ff[`SYNC_DATA +: 8];
    bus.ring_n    = s2_ff[`SYNC_RING +: 4];
    bus.ring_rise = s2_ff[`SYNC_RING +: 4] & ~prev_ff[`SYNC_RING +: 4];
    bus.rx        = s2_ff[`SYNC_RX +: 4];
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  reset_polarity_a: assert property (
    !bus.mode && !s2_ff[`SYNC_RST] |-> bus.reset_active)
    else $error("combined style low reset pin not seen as reset");
  single_edge_a: assert property (
    bus.ring_rise[3] |=> !bus.ring_rise[3])
    else $error("ring edge gave more than one event");
endmodule

// file: modem_model.sv
// Purpose: far side model of the four modem channels, ring indicator and receive lines
// Assumes: driven from the bench on the falling edge of ref_clk_in
// Notes:   ring indicator idles high (no ring); receive lines idle high
`timescale 1ns/100ps
module modem_model (
  input  wire logic                     ref_clk_in,
  output      quad_uart_pkg::chan_vec_t ring_n_out,
  output      quad_uart_pkg::chan_vec_t rx_out
);
  initial begin
    ring_n_out = 4'hf;
    rx_out     = 4'hf;
  end

  // one ring line per channel, active low
  task automatic ring(input int ch, input logic lvl);
    @(negedge ref_clk_in);
    ring_n_out[ch] = lvl;
  endtask

  task automatic send(input quad_uart_pkg::chan_vec_t v);
    @(negedge ref_clk_in);
    rx_out = v;
  endtask
endmodule

// file: quad_uart_defines.svh
// Purpose: offsets, field positions, reset values and widths of the quad serial host port
// Assumes: one 25 MHz clock; all host and modem pins arrive asynchronously
// Notes:   the behaviour list below is kept in step with the tags in the design files
//
// Behaviour
// - separate style: write strobe falling edge stores data at the register A0-A2 pick
// - write strobe pin exists only in separate style; otherwise it is read/write select
// - combined style: select high reads, low writes the register that chip select, A0-A4 pick
// - combined style merges interrupts of channels a to d onto one shared output
// - shared interrupt goes low when any channel has an enabled source pending
// - separate style: shared pin carries channel a interrupt, active high
// - separate style: high reset pin returns all registers and outputs to reset
// - while reset is held each channel transmit output and receive input are disabled
// - combined style: reset pin acts the same way but active low
// - each channel has its own ring indicator input and request-to-send output
// - low ring indicator input reports a ringing signal on that channel
// - low-to-high ring indicator transition raises a modem status interrupt condition
// - modem control bit 1 set drives request-to-send low, clear drives it high
// - after reset every request-to-send output is high
// - request-to-send steers flow only when enhanced feature bit 6 is set
// - separate style: read strobe falling edge drives register A0-A2 pick onto data bus
`ifndef QUAD_UART_DEFINES_SVH
`define QUAD_UART_DEFINES_SVH

`define NUM_CHAN      4
`define SYNC_W        26
`define SYNC_CS       0
`define SYNC_WR       1
`define SYNC_RD       2
`define SYNC_MODE     3
`define SYNC_RST      4
`define SYNC_RING     5
`define SYNC_RX       9
`define SYNC_ADDR     13
`define SYNC_DATA     18

`define REG_IER       3'h1
`define REG_ISR       3'h2
`define REG_MCR       3'h4
`define REG_MSR       3'h6
`define REG_EFR       3'h7

`define IER_RX        0
`define IER_TX        1
`define IER_LINE      2
`define IER_MODEM     3
`define MCR_RTS       1
`define EFR_AUTO_RTS  6
`define MSR_TERI      2
`define MSR_RING      6

`define ISR_NONE      8'h01
`define ISR_LINE      8'h06
`define ISR_RX        8'h04
`define ISR_TX        8'h02
`define ISR_MODEM     8'h00
`define REG_RESET     8'h00

`endif

// file: quad_uart_host_port.sv
// Purpose: host strobes, shared interrupt, reset and modem pins of a four channel serial port
// Assumes: datapath supplies interrupt source levels and transmit data on ref_clk_in
// Notes:   channel from A4-A3, register from A2-A0; output enable low while driving
`timescale 1ns/100ps
`include "quad_uart_defines.svh"
module quad_uart_host_port (
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      bus_mode_in,
  input  wire logic                      reset_pin_in,
  input  wire logic                      chip_select_n_in,
  input  wire logic                      host_write_strobe_n_in,
  input  wire logic                      host_read_strobe_n_in,
  input  wire logic [4:0]                addr_in,
  input  wire quad_uart_pkg::byte_t      data_in,
  output      quad_uart_pkg::byte_t      data_out,
  output      logic                      data_oe_n_out,
  input  wire quad_uart_pkg::chan_vec_t  ring_indicator_n_in,
  output      quad_uart_pkg::chan_vec_t  rts_n_out,
  output      quad_uart_pkg::chan_vec_t  auto_rts_en_out,
  input  wire quad_uart_pkg::chan_vec_t  rx_pin_in,
  output      quad_uart_pkg::chan_vec_t  rx_data_out,
  input  wire quad_uart_pkg::chan_vec_t  tx_data_in,
  output      quad_uart_pkg::chan_vec_t  tx_pin_out,
  input  wire quad_uart_pkg::chan_vec_t  rx_ready_in,
  input  wire quad_uart_pkg::chan_vec_t  tx_empty_in,
  input  wire quad_uart_pkg::chan_vec_t  line_status_in,
  output      quad_uart_pkg::chan_vec_t  channel_irq_out,
  output      logic                      shared_irq_out,
  output      logic                      device_reset_out
);

  // ****************************************
  // declarations
  // ****************************************
  host_bus_if bus ();

  quad_uart_pkg::byte_t      mem_ff [0:`NUM_CHAN-1][0:7];
  quad_uart_pkg::byte_t      nxt_mem [0:`NUM_CHAN-1][0:7];
  quad_uart_pkg::chan_vec_t  teri_ff;
  quad_uart_pkg::chan_vec_t  nxt_teri;
  quad_uart_pkg::byte_t      data_ff;
  quad_uart_pkg::byte_t      nxt_data;
  quad_uart_pkg::access_st_t st_ff;
  quad_uart_pkg::access_st_t nxt_st;
  quad_uart_pkg::chan_vec_t  irq_ff;
  quad_uart_pkg::chan_vec_t  nxt_irq;
  logic                      shared_ff;
  logic                      nxt_shared;
  quad_uart_pkg::chan_vec_t  tx_ff;
  quad_uart_pkg::chan_vec_t  nxt_tx;
  quad_uart_pkg::chan_vec_t  rx_ff;
  quad_uart_pkg::chan_vec_t  nxt_rx;
  quad_uart_pkg::chan_vec_t  pend;
  quad_uart_pkg::byte_t      isr [0:`NUM_CHAN-1];
  quad_uart_pkg::byte_t      rdata;
  logic [1:0]                ch;
  logic [2:0]                off;

  // ****************************************
  // pin synchroniser
  // ****************************************
  host_pin_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .pins_in    ({data_in, addr_in, rx_pin_in, ring_indicator_n_in, reset_pin_in,
                  bus_mode_in, host_read_strobe_n_in, host_write_strobe_n_in,
                  chip_select_n_in}),
    .bus        (bus.sync_side)
  );

  // ****************************************
  // interrupt status encoding
  // ****************************************
  function automatic quad_uart_pkg::byte_t isr_code(
    input quad_uart_pkg::byte_t interrupt_enable_reg,
    input logic                 rx,
    input logic                 tx,
    input logic                 ls,
    input logic                 ms
  );
    quad_uart_pkg::byte_t code;
    code = `ISR_NONE;
    if (interrupt_enable_reg[`IER_LINE] && ls) begin
      code = `ISR_LINE;
    end else if (interrupt_enable_reg[`IER_RX] && rx) begin
      code = `ISR_RX;
    end else if (interrupt_enable_reg[`IER_TX] && tx) begin
      code = `ISR_TX;
    end else if (interrupt_enable_reg[`IER_MODEM] && ms) begin
      code = `ISR_MODEM;
    end
    return code;
  endfunction

  function automatic logic writable(input logic [2:0] o);
    return (o != `REG_ISR) && (o != `REG_MSR);
  endfunction

  genvar c;
  generate
    for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_chan
      always_comb begin
        isr[c]  = isr_code(mem_ff[c][`REG_IER], rx_ready_in[c], tx_empty_in[c],
                           line_status_in[c], teri_ff[c]);
        pend[c] = ~isr[c][0];
      end
    end
  endgenerate

  // ****************************************
  // register read selection
  // ****************************************
  always_comb begin
    ch  = bus.addr[4:3];
    off = bus.addr[2:0];
    case (off)
      `REG_ISR: rdata = isr[ch];
      `REG_MSR: begin
        rdata = `REG_RESET;
        rdata[`MSR_RING] = ~bus.ring_n[ch];
        rdata[`MSR_TERI] = teri_ff[ch];
      end
      default:  rdata = mem_ff[ch][off];
    endcase
  end

  // ****************************************
  // register file and access state
  // ****************************************
  always_comb begin
    nxt_mem  = mem_ff;
    nxt_teri = teri_ff | bus.ring_rise;
    nxt_data = data_ff;
    nxt_st   = st_ff;
    case (st_ff)
      quad_uart_pkg::ST_IDLE: begin
        if (bus.rd_pulse) begin
          nxt_data = rdata;
          nxt_st   = quad_uart_pkg::ST_READ;
          if (off == `REG_MSR) begin
            nxt_teri[ch] = bus.ring_rise[ch];
          end
        end
      end
      quad_uart_pkg::ST_READ: begin
        if (!bus.rd_level) begin
          nxt_st = quad_uart_pkg::ST_IDLE;
        end
      end
      default: nxt_st = quad_uart_pkg::ST_IDLE;
    endcase
    if (bus.wr_pulse && writable(off)) begin
      nxt_mem[ch][off] = bus.data;
    end
    if (bus.reset_active) begin
      for (int i = 0; i < `NUM_CHAN; i++) begin
        for (int j = 0; j < 8; j++) begin
          nxt_mem[i][j] = `REG_RESET;
        end
      end
      nxt_teri = 4'h0;
      nxt_data = `REG_RESET;
      nxt_st   = quad_uart_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < `NUM_CHAN; i++) begin
        for (int j = 0; j < 8; j++) begin
          mem_ff[i][j] <= `REG_RESET;
        end
      end
      teri_ff <= 4'h0;
      data_ff <= `REG_RESET;
      st_ff   <= quad_uart_pkg::ST_IDLE;
    end else begin
      mem_ff  <= nxt_mem;
      teri_ff <= nxt_teri;
      data_ff <= nxt_data;
      st_ff   <= nxt_st;
    end
  end

  // ****************************************
  // interrupt and serial pin outputs
  // ****************************************
  always_comb begin
    nxt_irq    = pend;
    nxt_shared = bus.mode ? pend[0] : ~(|pend);
    nxt_tx     = tx_data_in;
    nxt_rx     = bus.rx;
    if (bus.reset_active) begin
      nxt_irq    = 4'h0;
      nxt_shared = ~bus.mode;
      nxt_tx     = 4'hf;
      nxt_rx     = 4'hf;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ff    <= 4'h0;
      shared_ff <= 1'b0;
      tx_ff     <= 4'hf;
      rx_ff     <= 4'hf;
    end else begin
      irq_ff    <= nxt_irq;
      shared_ff <= nxt_shared;
      tx_ff     <= nxt_tx;
      rx_ff     <= nxt_rx;
    end
  end

  generate
    for (c = 0; c < `NUM_CHAN; c = c + 1) begin : g_modem
      always_comb begin
        rts_n_out[c]       = ~mem_ff[c][`REG_MCR][`MCR_RTS];
        auto_rts_en_out[c] = mem_ff[c][`REG_EFR][`EFR_AUTO_RTS];
      end
    end
  endgenerate

  always_comb begin
    data_out         = data_ff;
    data_oe_n_out    = (st_ff != quad_uart_pkg::ST_READ);
    channel_irq_out  = irq_ff;
    shared_irq_out   = shared_ff;
    tx_pin_out       = tx_ff;
    rx_data_out      = rx_ff;
    device_reset_out = bus.reset_active;
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence mcr0_rts_set_s;
    bus.wr_pulse && !bus.reset_active && bus.addr == {2'b00, `REG_MCR} && bus.data[`MCR_RTS];
  endsequence
  sequence msr3_read_s;
    bus.rd_pulse && st_ff == quad_uart_pkg::ST_IDLE && !bus.reset_active
      && bus.addr == {2'b11, `REG_MSR};
  endsequence
  sequence efr2_auto_s;
    bus.wr_pulse && !bus.reset_active && bus.addr == {2'b10, `REG_EFR}
      && bus.data[`EFR_AUTO_RTS];
  endsequence

  rts_drive_a: assert property (mcr0_rts_set_s |=> !rts_n_out[0])
    else $error("modem control write did not drive rts low");
  auto_rts_a: assert property (efr2_auto_s |=> auto_rts_en_out[2])
    else $error("enhanced feature write did not enable auto rts");
  write_store_a: assert property (
    bus.wr_pulse && bus.mode && !bus.reset_active && bus.addr == {2'b11, `REG_IER}
      |=> mem_ff[3][`REG_IER] == $past(bus.data))
    else $error("write strobe did not store data");
  read_drive_a: assert property (
    bus.rd_pulse && st_ff == quad_uart_pkg::ST_IDLE && !bus.reset_active
      |=> !data_oe_n_out && data_out == $past(rdata))
    else $error("read strobe did not drive data bus");
  ring_level_a: assert property (msr3_read_s |=> data_out[`MSR_RING] == $past(~bus.ring_n[3]))
    else $error("ring level not reported");
  ring_event_a: assert property (
    bus.ring_rise[3] && !bus.reset_active && mem_ff[3][`REG_IER][`IER_MODEM]
      |=> teri_ff[3] ##1 channel_irq_out[3] || bus.reset_active)
    else $error("ring rise raised no modem interrupt");
  shared_low_a: assert property (
    !bus.mode && !bus.reset_active && |pend |=> !shared_irq_out)
    else $error("shared interrupt not low with pending channel");
  chan_a_pin_a: assert property (
    bus.mode && !bus.reset_active |=> shared_irq_out == $past(pend[0]))
    else $error("shared pin does not follow channel a");
  reset_clear_a: assert property (
    bus.reset_active |=> rts_n_out == 4'hf && tx_pin_out == 4'hf && rx_data_out == 4'hf)
    else $error("reset did not clear outputs");

endmodule

// file: quad_uart_pkg.sv
// Purpose: shared types of the quad serial host port
// Assumes: constants live in quad_uart_defines.svh
// Notes:   nothing here is imported; users write quad_uart_pkg::name
package quad_uart_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] chan_vec_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } access_st_t;
endpackage

// file: tb_quad_uart_host_port.sv
// Purpose: self-checking bench of the quad serial host port
// Assumes: inputs change on the falling edge; notes are compared by a watcher process
// Notes:   mode 1 separate strobes, mode 0 combined read/write select
`timescale 1ns/100ps
`include "quad_uart_defines.svh"
module tb_quad_uart_host_port;
  logic                     clk, rst, mode, rpin, cs_n, wr_n, rd_n, oe_n, shirq, devrst;
  logic [4:0]               addr;
  quad_uart_pkg::byte_t     wdat, rdat, rd_cap, oe_cap, msk;
  quad_uart_pkg::chan_vec_t ring_n, rts_n, auto_rts, rxp, rxd, txd, txp, rxr, txe, lsi, chirq;
  int                       miscompares, checks;
  int                       qid[$];
  quad_uart_pkg::byte_t     qexp[$];
  string                    nm[9] = '{"rts_n", "auto_rts", "shared_irq", "channel_irq",
                                      "rx_data", "tx_pin", "device_reset", "read_data",
                                      "data_oe_n"};

  always #20 clk = ~clk;

  modem_model modem_u (.ref_clk_in(clk), .ring_n_out(ring_n), .rx_out(rxp));

  quad_uart_host_port dut_u (
    .ref_clk_in(clk), .rst_in(rst), .bus_mode_in(mode), .reset_pin_in(rpin),
    .chip_select_n_in(cs_n), .host_write_strobe_n_in(wr_n), .host_read_strobe_n_in(rd_n),
    .addr_in(addr), .data_in(wdat), .data_out(rdat), .data_oe_n_out(oe_n),
    .ring_indicator_n_in(ring_n), .rts_n_out(rts_n), .auto_rts_en_out(auto_rts),
    .rx_pin_in(rxp), .rx_data_out(rxd), .tx_data_in(txd), .tx_pin_out(txp),
    .rx_ready_in(rxr), .tx_empty_in(txe), .line_status_in(lsi),
    .channel_irq_out(chirq), .shared_irq_out(shirq), .device_reset_out(devrst)
  );

  // ****************************************
  // notes and watcher
  // ****************************************
  event look;

  function automatic quad_uart_pkg::byte_t obs(input int id);
    case (id)
      0: obs = {4'h0, rts_n};
      1: obs = {4'h0, auto_rts};
      2: obs = {7'h00, shirq};
      3: obs = {4'h0, chirq};
      4: obs = {4'h0, rxd};
      5: obs = {4'h0, txp};
      6: obs = {7'h00, devrst};
      8: obs = oe_cap;
      default: obs = rd_cap & msk;
    endcase
  endfunction

  task automatic note(input int id, input quad_uart_pkg::byte_t e);
    qid.push_back(id);
    qexp.push_back(e);
    ->look;
  endtask

  initial begin
    forever begin
      @(look);
      while (qid.size() > 0) begin
        int                   id;
        quad_uart_pkg::byte_t e;
        quad_uart_pkg::byte_t o;
        id = qid.pop_front();
        e = qexp.pop_front();
        o = obs(id);
        checks++;
        if (o !== e) begin
          miscompares++;
          $display("ERROR %s expected %h seen %h", nm[id], e, o);
        end
      end
    end
  end

  // ****************************************
  // host bus tasks
  // ****************************************
  task automatic acc(input logic wr, input logic [4:0] a, input quad_uart_pkg::byte_t d);
    @(negedge clk);
    addr = a;
    wdat = d;
    if (mode) begin
      cs_n = 1'b0;
      wr_n = ~wr;
      rd_n = wr;
    end else begin
      wr_n = ~wr;
    end
    @(negedge clk);
    if (!mode) cs_n = 1'b0;
    repeat (5) @(negedge clk);
    rd_cap = rdat;
    oe_cap = {7'h00, oe_n};
    cs_n = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  task automatic rd(input logic [4:0] a, input quad_uart_pkg::byte_t e, input quad_uart_pkg::byte_t m);
    acc(1'b0, a, 8'h00);
    msk = m;
    note(7, e & m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    quad_uart_pkg::chan_vec_t r, v, t;
    quad_uart_pkg::byte_t     d;
    clk = 1'b0; rst = 1'b1; mode = 1'b1; rpin = 1'b0; cs_n = 1'b1; wr_n = 1'b1; rd_n = 1'b1;
    addr = 5'h00; wdat = 8'h00; txd = 4'hf; rxr = 4'h0; txe = 4'h0; lsi = 4'h0;
    rd_cap = 8'h00; oe_cap = 8'h01; msk = 8'hff; miscompares = 0; checks = 0;
    void'($urandom(90310));
    wt(16);
    rst = 1'b0;
    wt(4);
    note(0, 8'h0f);
    note(5, 8'h0f);
    note(4, 8'h0f);
    note(3, 8'h00);
    note(6, 8'h00);
    $display("test reset done");

    r = 4'hf;
    for (int ch = 0; ch < 4; ch++) begin
      acc(1'b1, {ch[1:0], `REG_MCR}, 8'h02);
      r[ch] = 1'b0;
      note(0, {4'h0, r});
    end
    acc(1'b1, {2'd1, `REG_MCR}, 8'h00);
    note(0, 8'h02);
    acc(1'b1, {2'd2, `REG_EFR}, 8'h40);
    note(1, 8'h04);
    note(8, 8'h01);
    rd({2'd0, `REG_MCR}, 8'h02, 8'hff);
    note(8, 8'h00);
    d = 8'($urandom());
    acc(1'b1, {2'd3, 3'h5}, d);
    rd({2'd3, 3'h5}, d, 8'hff);
    $display("test separate access done");

    rxr = 4'h2;
    acc(1'b1, {2'd1, `REG_IER}, 8'h01);
    note(3, 8'h02);
    note(2, 8'h00);
    rxr = 4'h3;
    acc(1'b1, {2'd0, `REG_IER}, 8'h01);
    note(3, 8'h03);
    note(2, 8'h01);
    rd({2'd0, `REG_ISR}, `ISR_RX, 8'hff);
    rxr = 4'h0;
    wt(3);
    note(2, 8'h00);
    $display("test separate interrupt done");

    acc(1'b1, {2'd3, `REG_IER}, 8'h08);
    modem_u.ring(3, 1'b0);
    wt(5);
    rd({2'd3, `REG_MSR}, 8'h40, 8'h44);
    modem_u.ring(3, 1'b1);
    wt(5);
    note(3, 8'h08);
    rd({2'd3, `REG_MSR}, 8'h04, 8'h44);
    rd({2'd3, `REG_MSR}, 8'h00, 8'h44);
    note(3, 8'h00);
    $display("test ring done");

    for (int i = 0; i < 4; i++) begin
      v = 4'($urandom());
      t = 4'($urandom());
      modem_u.send(v);
      txd = t;
      wt(5);
      note(4, {4'h0, v});
      note(5, {4'h0, t});
    end
    $display("test serial lines done");

    txd = 4'h0;
    modem_u.send(4'h0);
    rpin = 1'b1;
    wt(5);
    note(6, 8'h01);
    note(0, 8'h0f);
    note(1, 8'h00);
    note(5, 8'h0f);
    note(4, 8'h0f);
    rpin = 1'b0;
    wt(5);
    note(6, 8'h00);
    note(0, 8'h0f);
    $display("test reset pin separate done");

    mode = 1'b0;
    rpin = 1'b1;
    txd = 4'hf;
    wt(6);
    note(6, 8'h00);
    acc(1'b1, {2'd2, `REG_MCR}, 8'h02);
    note(0, 8'h0b);
    rd({2'd2, `REG_MCR}, 8'h02, 8'hff);
    acc(1'b1, {2'd3, `REG_IER}, 8'h01);
    acc(1'b1, {2'd1, `REG_IER}, 8'h02);
    note(2, 8'h01);
    txe = 4'h2;
    wt(3);
    note(2, 8'h00);
    txe = 4'h0;
    rxr = 4'h8;
    wt(3);
    note(3, 8'h08);
    note(2, 8'h00);
    rd({2'd3, `REG_ISR}, `ISR_RX, 8'hff);
    rpin = 1'b0;
    wt(5);
    note(6, 8'h01);
    note(0, 8'h0f);
    rpin = 1'b1;
    wt(5);
    note(2, 8'h01);
    $display("test combined style done");
    conclude;
  end
endmodule
